// ### rtl/uart_irq_top.v
// UART channel interrupt, reset and receive flow pacing logic
// Contract
// [R1] Threshold field times four gives FIFO level
// [R2] FIFO still accepts in-flight char after stop
// [R3] Send resume token when drained to resume
// [R4] Identification reads 01 after reset
// [R5] Line control resets to 1d
// [R6] Line status resets with bits 5,6
// [R7] Modem deltas clear, upper bits follow pins
// [R8] Alternate function resets to 10
// [R9] Other control registers and pointers clear
// [R10] Divisor, scratch, token chars survive reset
// [R11] Reset pins: tx,rts,dtr,rxrdy high, txrdy low
// [R12] Six enabled prioritised sources drive irq; the code ORs seven, pend[6:0]
// [R13] Clearing enables disables interrupt system
// [R14] Code reports top source, 000001 idle
// [R15] Line errors top; overrun clears on read
// [R16] Stale data timeout, cleared by data read
// [R17] Data available, cleared by data read
// [R18] Transmit empty, cleared by ident read/write
// [R19] Modem change, cleared by modem read
// [R20] Xoff/special, cleared by Xon or read
// [R21] RTS/CTS going inactive, cleared by read
// [R22] Status bit 7 while errored chars remain
// [R23] Status bits 4-2 show head char errors
// [R24] Enable bits 3-0 select interrupt mode
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "uart_irq_defines.vh"
module uart_irq_top (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Wishbone slave
  input wire wb_cyc,
  input wire wb_stb,
  input wire wb_we,
  input wire [7:0] wb_adr,
  input wire [3:0] wb_sel,
  input wire [31:0] wb_dat_w,
  output reg [31:0] wb_dat_r,
  output reg wb_ack,
  // Receiver character stream
  input wire rx_valid,
  input wire [7:0] rx_data,
  input wire rx_fe,
  input wire rx_pe,
  input wire rx_bi,
  input wire rx_stale,
  // Transmitter side
  input wire tx_pop,
  input wire tx_busy,
  input wire tx_ser,
  // Flow token detectors
  input wire xoff_det,
  input wire xon_det,
  input wire special_det,
  // Modem inputs, active low
  input wire cts_n,
  input wire dsr_n,
  input wire ri_n,
  input wire cd_n,
  // Pins and tokens
  output reg tx_line,
  output reg rts_n,
  output reg dtr_n,
  output reg rx_ready_out,
  output reg tx_ready_out,
  output reg irq,
  output reg stop_tok,
  output reg resume_tok,
  output reg [7:0] tok_char
);
  // Bus handshake: one wait state so FIFO head data has settled
  reg stage_r;
  wire req = wb_cyc & wb_stb & ~wb_ack;
  wire acc = req & stage_r;
  wire wr = acc & wb_we & wb_sel[0];
  wire rd = acc & ~wb_we;
  wire [7:0] wd = wb_dat_w[7:0];

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stage_r <= 1'b0;
      wb_ack <= 1'b0;
    end else begin
      wb_ack <= acc;
      stage_r <= req & ~stage_r;
    end
  end

  wire wr_thr = wr & (wb_adr == `A_DATA);
  wire wr_fcr = wr & (wb_adr == `A_IIR_FCR);
  wire rd_rhr = rd & (wb_adr == `A_DATA);
  wire rd_iir = rd & (wb_adr == `A_IIR_FCR);
  wire rd_lsr = rd & (wb_adr == `A_LSR);
  wire rd_msr = rd & (wb_adr == `A_MSR);

  // Control registers
  reg [7:0] ier_r, fcr_r, lcr_r, mcr_r, efr_r, tcr_r, tlr_r, afr_r;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ier_r <= `IER_RST; // R9
      fcr_r <= `FCR_RST; // R9
      lcr_r <= `LCR_RST; // R5
      mcr_r <= `MCR_RST; // R9
      efr_r <= `EFR_RST; // R9
      tcr_r <= `TCR_RST; // R9
      tlr_r <= `TLR_RST; // R9
      afr_r <= `AFR_RST; // R8
    end else if (wr) begin
      case (wb_adr)
        `A_IER: ier_r <= wd;
        `A_IIR_FCR: fcr_r <= wd;
        `A_LCR: lcr_r <= wd;
        `A_MCR: mcr_r <= wd;
        `A_EFR: efr_r <= wd;
        `A_TCR: tcr_r <= wd;
        `A_TLR: tlr_r <= wd;
        `A_AFR: afr_r <= wd;
        default: ;
      endcase
    end
  end

  // Registers that hold their contents across reset
  reg [7:0] dll_r, dlh_r, spr_r, resume_char_a_r, resume_char_b_r, stop_char_a_r, stop_char_b_r;
  always @(posedge clk) begin
    if (wr) begin
      case (wb_adr) // R10
        `A_DLL: dll_r <= wd;
        `A_DLH: dlh_r <= wd;
        `A_SPR: spr_r <= wd;
        `A_RESUME_CHAR_A: resume_char_a_r <= wd;
        `A_RESUME_CHAR_B: resume_char_b_r <= wd;
        `A_STOP_CHAR_A: stop_char_a_r <= wd;
        `A_STOP_CHAR_B: stop_char_b_r <= wd;
        default: ;
      endcase
    end
  end

  // Receive FIFO
  reg [5:0] wr_ptr_r, rd_ptr_r;
  reg [6:0] rx_cnt_r, err_cnt_r;
  wire [10:0] head;
  wire fifo_on = fcr_r[`FCR_EN];
  wire [6:0] cap = fifo_on ? `FIFO_DEPTH : 7'd1;
  wire rx_full = rx_cnt_r >= cap;
  // Room above the stop threshold absorbs the char already in flight
  wire push = rx_valid & ~rx_full; // R2
  wire rx_nemp = rx_cnt_r != 7'd0;
  wire pop = rd_rhr & rx_nemp;
  wire in_err = rx_fe | rx_pe | rx_bi;
  wire head_err = |head[10:8];
  wire rx_clr = wr_fcr & wd[`FCR_RXRST];

  rx_fifo_mem u_mem (
    .clk(clk),
    .we(push),
    .waddr(wr_ptr_r),
    .wdata({rx_bi, rx_fe, rx_pe, rx_data}),
    .raddr(rd_ptr_r),
    .rdata(head)
  );

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_r <= 6'h00; // R9
      rd_ptr_r <= 6'h00; // R9
      rx_cnt_r <= 7'h00;
      err_cnt_r <= 7'h00;
    end else if (rx_clr) begin
      wr_ptr_r <= 6'h00;
      rd_ptr_r <= 6'h00;
      rx_cnt_r <= 7'h00;
      err_cnt_r <= 7'h00;
    end else begin
      wr_ptr_r <= wr_ptr_r + {5'h00, push};
      rd_ptr_r <= rd_ptr_r + {5'h00, pop};
      rx_cnt_r <= rx_cnt_r + {6'h00, push} - {6'h00, pop};
      // Errored characters still queued
      err_cnt_r <= err_cnt_r + {6'h00, push & in_err} -
                   {6'h00, pop & head_err}; // R22
    end
  end

  // Transmit FIFO occupancy
  reg [6:0] tx_cnt_r;
  wire tx_push = wr_thr & (tx_cnt_r < cap);
  wire tx_take = tx_pop & (tx_cnt_r != 7'd0);
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_cnt_r <= 7'h00; // R9
    end else if (wr_fcr & wd[`FCR_TXRST]) begin
      tx_cnt_r <= 7'h00;
    end else begin
      tx_cnt_r <= tx_cnt_r + {6'h00, tx_push} - {6'h00, tx_take};
    end
  end

  // Line status
  reg overrun_r;
  wire thr_empty = tx_cnt_r == 7'd0;
  wire [2:0] head_stat = rx_nemp ? head[10:8] : 3'b000; // R23
  wire [7:0] line_stat_reg = {err_cnt_r != 7'd0, thr_empty & ~tx_busy, // R22
                    thr_empty, head_stat, overrun_r, rx_nemp}; // R6

  // Modem status: deltas only armed once the first pin sample exists
  reg [3:0] mprev_r, mdelta_r;
  reg armed_r;
  wire [3:0] live = ~{cd_n, ri_n, dsr_n, cts_n};
  wire [3:0] mset = {live[3] ^ mprev_r[3], mprev_r[2] & ~live[2],
                     live[1] ^ mprev_r[1], live[0] ^ mprev_r[0]};
  wire [7:0] modem_stat_reg = {live, mdelta_r}; // R7

  // Trigger and flow thresholds in FIFO characters
  wire [6:0] rx_trig = (tlr_r[7:4] != 4'h0) ?
                       {1'b0, tlr_r[7:4], 2'b00} : `RX_TRIG_DFLT;
  wire [6:0] tx_trig = (tlr_r[3:0] != 4'h0) ?
                       {1'b0, tlr_r[3:0], 2'b00} : `TX_TRIG_DFLT;
  wire [6:0] halt_lvl = {1'b0, tcr_r[3:0], 2'b00}; // R1
  wire [6:0] resume_lvl = {1'b0, tcr_r[7:4], 2'b00}; // R1

  // Interrupt sources
  reg timeout_r, thr_int_r, thr_prev_r, xoff_int_r, by_special_r;
  reg cts_prev_r, rts_prev_r, ctsrts_r;
  wire [5:0] code;
  wire rhr_cond = fifo_on ? (rx_cnt_r >= rx_trig) : rx_nemp; // R17
  wire thr_cond = fifo_on ? ((`FIFO_DEPTH - tx_cnt_r) >= tx_trig) :
                  thr_empty; // R18
  wire [6:0] pend;
  assign pend[0] = ier_r[2] & (overrun_r | (err_cnt_r != 7'd0)); // R15
  assign pend[1] = ier_r[0] & timeout_r; // R16
  assign pend[2] = ier_r[0] & rhr_cond; // R24
  assign pend[3] = ier_r[1] & thr_int_r; // R24
  assign pend[4] = ier_r[3] & (|mdelta_r); // R19
  assign pend[5] = ier_r[5] & xoff_int_r; // R20
  assign pend[6] = (ier_r[6] | ier_r[7]) & ctsrts_r; // R21

  irq_prio_enc u_enc (
    .pend(pend),
    .code(code)
  );

  wire clr_thr = wr_thr | (rd_iir & (code == `IC_THR)); // R18
  wire clr_xoff = (xon_det & ~by_special_r) |
                  (rd_iir & by_special_r & (code == `IC_XOFF)); // R20
  wire clr_cr = rd_iir & (code == `IC_CTSRTS); // R21
  wire cr_rise = (cts_n & ~cts_prev_r) | (rts_n & ~rts_prev_r);

  // Sticky flags; a new event always wins over a same-cycle clear
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      overrun_r <= 1'b0;
      timeout_r <= 1'b0;
      thr_int_r <= 1'b0;
      thr_prev_r <= 1'b0;
      xoff_int_r <= 1'b0;
      by_special_r <= 1'b0;
      cts_prev_r <= 1'b1;
      rts_prev_r <= 1'b1;
      ctsrts_r <= 1'b0;
      mprev_r <= 4'h0;
      mdelta_r <= 4'h0; // R7
      armed_r <= 1'b0;
    end else begin
      overrun_r <= (overrun_r & ~rd_lsr) | (rx_valid & rx_full); // R15
      timeout_r <= (timeout_r & ~rd_rhr) | (rx_stale & rx_nemp); // R16
      thr_prev_r <= thr_cond;
      thr_int_r <= (thr_int_r & ~clr_thr) | (thr_cond & ~thr_prev_r);
      if (xoff_det | special_det) begin
        xoff_int_r <= 1'b1; // R20
        by_special_r <= special_det & ~xoff_det;
      end else if (clr_xoff) begin
        xoff_int_r <= 1'b0;
      end
      cts_prev_r <= cts_n;
      rts_prev_r <= rts_n;
      ctsrts_r <= (ctsrts_r & ~clr_cr) | cr_rise; // R21
      mprev_r <= live;
      armed_r <= 1'b1;
      mdelta_r <= (mdelta_r & {4{~rd_msr}}) |
                  (mset & {4{armed_r}}); // R19
    end
  end

  // Receive flow pacing: stop token at the halt level, resume on drain
  reg halted_r;
  wire sw_tx = efr_r[3] | efr_r[2];
  wire fc_on = sw_tx | efr_r[`EFR_ARTS];
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      halted_r <= 1'b0;
      stop_tok <= 1'b0;
      resume_tok <= 1'b0;
      tok_char <= 8'h00;
    end else begin
      stop_tok <= 1'b0;
      resume_tok <= 1'b0;
      if (fc_on & ~halted_r & (halt_lvl != 7'd0) &
          (rx_cnt_r >= halt_lvl)) begin
        halted_r <= 1'b1; // R1
        stop_tok <= sw_tx;
        tok_char <= efr_r[3] ? stop_char_a_r : stop_char_b_r;
      end else if (halted_r & ((rx_cnt_r <= resume_lvl) | ~fc_on)) begin
        // Disabling pacing while halted still releases the far sender
        halted_r <= 1'b0;
        resume_tok <= sw_tx | ~fc_on; // R3
        tok_char <= efr_r[3] ? resume_char_a_r : resume_char_b_r;
      end
    end
  end

  // Pins and interrupt output
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_line <= 1'b1; // R11
      rts_n <= 1'b1; // R11
      dtr_n <= 1'b1; // R11
      rx_ready_out <= 1'b1; // R11
      tx_ready_out <= 1'b0; // R11
      irq <= 1'b0;
    end else begin
      tx_line <= lcr_r[`LCR_BRK] ? 1'b0 : tx_ser;
      rts_n <= efr_r[`EFR_ARTS] ? halted_r : ~mcr_r[`MCR_RTS];
      dtr_n <= ~mcr_r[`MCR_DTR];
      rx_ready_out <= ~rx_nemp;
      tx_ready_out <= tx_cnt_r >= cap;
      // No enable bit set means the pin never asserts
      irq <= |pend; // R12 R13
    end
  end

  // Read data, captured on the answering edge
  reg [7:0] rmux;
  always @* begin
    case (wb_adr)
      `A_DATA: rmux = head[7:0];
      `A_IER: rmux = ier_r;
      `A_IIR_FCR: rmux = {fifo_on, fifo_on, code}; // R4 R14
      `A_LCR: rmux = lcr_r;
      `A_MCR: rmux = mcr_r;
      `A_LSR: rmux = line_stat_reg;
      `A_MSR: rmux = modem_stat_reg;
      `A_SPR: rmux = spr_r;
      `A_DLL: rmux = dll_r;
      `A_DLH: rmux = dlh_r;
      `A_EFR: rmux = efr_r;
      `A_TCR: rmux = tcr_r;
      `A_TLR: rmux = tlr_r;
      `A_AFR: rmux = afr_r;
      `A_RESUME_CHAR_A: rmux = resume_char_a_r;
      `A_RESUME_CHAR_B: rmux = resume_char_b_r;
      `A_STOP_CHAR_A: rmux = stop_char_a_r;
      `A_STOP_CHAR_B: rmux = stop_char_b_r;
      default: rmux = 8'h00;
    endcase
  end

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wb_dat_r <= 32'h0000_0000;
    end else if (rd) begin
      wb_dat_r <= {24'h00_0000, rmux};
    end
  end
endmodule // uart_irq_top

// ### rtl/uart_irq_defines.vh
// Register map, reset values and interrupt codes for the UART channel
`ifndef UART_IRQ_DEFINES_VH
`define UART_IRQ_DEFINES_VH

// Byte addresses on the Wishbone bus
`define A_DATA 8'h00
`define A_IER 8'h04
`define A_IIR_FCR 8'h08
`define A_LCR 8'h0c
`define A_MCR 8'h10
`define A_LSR 8'h14
`define A_MSR 8'h18
`define A_SPR 8'h1c
`define A_DLL 8'h20
`define A_DLH 8'h24
`define A_EFR 8'h28
`define A_TCR 8'h2c
`define A_TLR 8'h30
`define A_AFR 8'h34
`define A_RESUME_CHAR_A 8'h38
`define A_RESUME_CHAR_B 8'h3c
`define A_STOP_CHAR_A 8'h40
`define A_STOP_CHAR_B 8'h44

// Reset values
`define IER_RST 8'h00
`define FCR_RST 8'h00
`define LCR_RST 8'h1d
`define MCR_RST 8'h00
`define EFR_RST 8'h00
`define TCR_RST 8'h00
`define TLR_RST 8'h00
`define AFR_RST 8'h10

// Field positions
`define FCR_EN 0
`define FCR_RXRST 1
`define FCR_TXRST 2
`define LCR_BRK 6
`define MCR_DTR 0
`define MCR_RTS 1
`define EFR_ARTS 6

// Identification codes
`define IC_NONE 6'h01
`define IC_LSR 6'h06
`define IC_TMO 6'h0c
`define IC_RHR 6'h04
`define IC_THR 6'h02
`define IC_MSR 6'h00
`define IC_XOFF 6'h10
`define IC_CTSRTS 6'h20

// FIFO sizing and default trigger levels
`define FIFO_DEPTH 7'd64
`define RX_TRIG_DFLT 7'd1
`define TX_TRIG_DFLT 7'd32

`endif

// ### rtl/rx_fifo_mem.v
// Receive FIFO storage: 64 words of data plus error flags, registered read
`timescale 1ns/1ps
module rx_fifo_mem (
  // Clock
  input wire clk,
  // Write port
  input wire we,
  input wire [5:0] waddr,
  input wire [10:0] wdata,
  // Read port
  input wire [5:0] raddr,
  output reg [10:0] rdata
);
  reg [10:0] mem [0:63];

  always @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // rx_fifo_mem

// ### rtl/irq_prio_enc.v
// Fixed-priority encoder from pending sources to identification code
`timescale 1ns/1ps
`include "uart_irq_defines.vh"
module irq_prio_enc (
  // Pending sources, bit 0 highest priority
  input wire [6:0] pend,
  // Identification code
  output wire [5:0] code
);
  function [5:0] encode;
    input [6:0] p;
    begin
      casez (p)
        7'b??????1: encode = `IC_LSR;
        7'b?????10: encode = `IC_TMO;
        7'b????100: encode = `IC_RHR;
        7'b???1000: encode = `IC_THR;
        7'b??10000: encode = `IC_MSR;
        7'b?100000: encode = `IC_XOFF;
        7'b1000000: encode = `IC_CTSRTS;
        default: encode = `IC_NONE;
      endcase
    end
  endfunction

  assign code = encode(pend);
endmodule // irq_prio_enc

// ### sim/remote_sender.sv
// Far-end sender that streams bytes and obeys the flow tokens
`timescale 1ns/1ps
module remote_sender (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Control from bench and device
  input wire go,
  input wire stop_tok,
  input wire resume_tok,
  // Byte stream
  output reg rx_valid,
  output reg [7:0] rx_data
);
  reg [7:0] n_r;
  reg halted_r;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      n_r <= 8'h00;
      halted_r <= 1'b0;
      rx_valid <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_valid <= 1'b0;
      // Idle data keeps moving so a stale byte is never trusted
      rx_data <= ~rx_data;
      if (go && !rx_valid && !halted_r) begin
        rx_valid <= 1'b1;
        rx_data <= n_r;
        n_r <= n_r + 8'h01;
      end
      // A byte launched at the stop edge is still in flight
      if (stop_tok) begin
        halted_r <= 1'b1;
      end
      if (resume_tok) begin
        halted_r <= 1'b0;
      end
    end
  end
endmodule // remote_sender

// ### sim/uart_irq_sva.sv
// Port checker for interrupt, reset and pacing behaviour
`timescale 1ns/1ps
`include "uart_irq_defines.vh"
module uart_irq_checker (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Bus
  input wire wb_we,
  input wire [7:0] wb_adr,
  input wire [3:0] wb_sel,
  input wire [31:0] wb_dat_w,
  input wire [31:0] wb_dat_r,
  input wire wb_ack,
  // Events and pins
  input wire rx_valid,
  input wire rx_fe,
  input wire cts_n,
  input wire dsr_n,
  input wire rx_ready_out,
  input wire tx_line,
  input wire rts_n,
  input wire dtr_n,
  input wire tx_ready_out,
  input wire irq,
  input wire stop_tok,
  input wire resume_tok
);
  // Enable shadow lags the device copy by one edge, safe for these checks
  reg [7:0] ier_r;
  wire iir_rd = wb_ack && !wb_we && wb_adr == `A_IIR_FCR;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ier_r <= 8'h00;
    end else if (wb_ack && wb_we && wb_sel[0] && wb_adr == `A_IER) begin
      ier_r <= wb_dat_w[7:0];
    end
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!resetn);
  property p_rst_pins;
    $rose(resetn) |-> tx_line && rts_n && dtr_n && rx_ready_out
      && !tx_ready_out && !irq;
  endproperty
  a_rst_pins: assert property (p_rst_pins) else $error("reset pins");
  property p_off;
    ((ier_r & 8'hef) == 8'h00) [*2] |-> !irq;
  endproperty
  a_off: assert property (p_off) else $error("irq while disabled");
  property p_idle;
    iir_rd && !irq |-> wb_dat_r[5:0] == 6'h01;
  endproperty
  a_idle: assert property (p_idle) else $error("idle code");
  property p_busy;
    iir_rd && irq |-> !wb_dat_r[0];
  endproperty
  a_busy: assert property (p_busy) else $error("pending code");
  property p_rx;
    rx_valid && rx_ready_out && ier_r[0] |-> ##[1:4] irq;
  endproperty
  a_rx: assert property (p_rx) else $error("no rx irq");
  property p_line;
    rx_valid && rx_fe && ier_r[2] |-> ##[1:4] irq;
  endproperty
  a_line: assert property (p_line) else $error("no line irq");
  property p_cts;
    $rose(cts_n) && ier_r[7:6] != 2'b00 |-> ##[1:3] irq;
  endproperty
  a_cts: assert property (p_cts) else $error("no cts irq");
  property p_msr;
    $changed(dsr_n) && ier_r[3] |-> ##[1:3] irq;
  endproperty
  a_msr: assert property (p_msr) else $error("no modem irq");
  property p_resume;
    resume_tok |-> !stop_tok ##1 !resume_tok;
  endproperty
  a_resume: assert property (p_resume) else $error("resume pulse");
  property p_stop;
    stop_tok |=> !stop_tok [*2];
  endproperty
  a_stop: assert property (p_stop) else $error("stop repeats");
  c_irq: cover property (iir_rd && irq);
  c_stop: cover property (stop_tok);
  c_resume: cover property (resume_tok);
endmodule // uart_irq_checker
bind uart_irq_top uart_irq_checker chk_i (.clk, .resetn, .wb_we, .wb_adr,
  .wb_sel, .wb_dat_w, .wb_dat_r, .wb_ack, .rx_valid, .rx_fe, .cts_n, .dsr_n,
  .rx_ready_out, .tx_line, .rts_n, .dtr_n, .tx_ready_out, .irq, .stop_tok,
  .resume_tok);

// ### sim/uart_irq_top_bench.sv
// Bench for the UART interrupt, reset and receive pacing block
`timescale 1ns/1ps
`include "uart_irq_defines.vh"
module uart_irq_top_bench;
  reg clk = 1'b0;
  reg resetn = 1'b0;
  reg wb_cyc = 1'b0;
  reg wb_stb = 1'b0;
  reg wb_we = 1'b0;
  reg [7:0] wb_adr = 8'h00;
  reg [31:0] wb_dat_w = 32'h0;
  reg go = 1'b0;
  reg fl = 1'b0;
  reg res_seen = 1'b0;
  reg [2:0] err = 3'h0;
  reg [3:0] det = 4'h0;
  reg [3:0] mdm = 4'hf;
  reg [7:0] rdat;
  integer fail_count = 0;
  integer n_tests = 0;
  integer n_push = 0;
  integer i;
  wire [31:0] wb_dat_r;
  wire [7:0] rx_data;
  wire [7:0] tok_char;
  wire wb_ack, rx_valid, tx_line, rts_n, dtr_n, rx_ready_out;
  wire tx_ready_out, irq, stop_tok, resume_tok;
  reg [7:0] ra [0:10] = '{8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18,
    8'h28, 8'h2c, 8'h30, 8'h34, 8'h48};
  reg [7:0] rv [0:10] = '{8'h00, 8'h01, 8'h1d, 8'h00, 8'h60, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h10, 8'h00};
  uart_irq_top uut (.clk(clk), .resetn(resetn), .wb_cyc(wb_cyc),
    .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(4'h1),
    .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_fe(err[0]),
    .rx_pe(err[1]), .rx_bi(err[2]), .rx_stale(det[3]), .tx_pop(1'b0),
    .tx_busy(1'b0), .tx_ser(1'b1), .xoff_det(det[0]), .xon_det(det[1]),
    .special_det(det[2]), .cts_n(mdm[0]), .dsr_n(mdm[1]), .ri_n(mdm[2]),
    .cd_n(mdm[3]), .tx_line(tx_line), .rts_n(rts_n), .dtr_n(dtr_n),
    .rx_ready_out(rx_ready_out), .tx_ready_out(tx_ready_out), .irq(irq),
    .stop_tok(stop_tok), .resume_tok(resume_tok), .tok_char(tok_char));
  remote_sender peer (.clk(clk), .resetn(resetn), .go(go),
    .stop_tok(stop_tok), .resume_tok(resume_tok), .rx_valid(rx_valid),
    .rx_data(rx_data));
  always #20 clk = ~clk;
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD %0t got %h want %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [7:0] a, input [7:0] d);
    integer k;
    begin
      wb_we <= w;
      wb_adr <= a;
      wb_dat_w <= {24'h0, d};
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      k = 0;
      @(posedge clk);
      // Ack is sampled on the rising edge; the request stands until then
      while (wb_ack !== 1'b1) begin
        k = k + 1;
        if (k > 20) begin
          fail_count = fail_count + 1;
          $display("BAD %0t bus timeout", $time);
          report_and_stop;
        end
        @(posedge clk);
      end
      rdat = wb_dat_r[7:0];
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      wb_we <= 1'b0;
      @(posedge clk);
    end
  endtask
  task rc(input [7:0] a, input [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      chk(rdat, e);
    end
  endtask
  task rst;
    begin
      resetn <= 1'b0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
    end
  endtask
  task snd(input [2:0] e);
    begin
      err <= e;
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      repeat (6) @(posedge clk);
    end
  endtask
  task pl(input [3:0] m);
    begin
      det <= m;
      @(posedge clk);
      det <= 4'h0;
      repeat (4) @(posedge clk);
    end
  endtask
  task setm(input [3:0] v);
    begin
      mdm <= v;
      repeat (4) @(posedge clk);
    end
  endtask
  always @(posedge clk) begin
    if (rx_valid && fl) begin
      n_push <= n_push + 1;
    end
    if (stop_tok) begin
      chk(n_push[7:0], 8'd60);
      chk(tok_char, 8'h0f);
    end
    if (resume_tok) begin
      res_seen <= 1'b1;
      chk(tok_char, 8'h0d);
    end
  end
  initial begin
    @(posedge clk);
    rst;
    chk({3'h0, tx_line, rts_n, dtr_n, rx_ready_out, tx_ready_out},
      8'h1e);
    bus(1'b1, `A_SPR, 8'ha5);
    bus(1'b1, `A_DLH, 8'h3c);
    bus(1'b1, `A_STOP_CHAR_A, 8'h0f);
    bus(1'b1, `A_RESUME_CHAR_A, 8'h0d);
    bus(1'b1, `A_LCR, 8'h03);
    rst;
    for (i = 0; i < 11; i = i + 1) begin
      rc(ra[i], rv[i]);
    end
    rc(`A_SPR, 8'ha5);
    rc(`A_DLH, 8'h3c);
    $display("reset test done");
    bus(1'b1, `A_IER, 8'h02);
    chk({7'h0, irq}, 8'h01);
    rc(`A_IIR_FCR, 8'h02);
    rc(`A_IIR_FCR, 8'h01);
    bus(1'b1, `A_IER, 8'h10);
    pl(4'h1);
    chk({7'h0, irq}, 8'h00);
    bus(1'b1, `A_IER, 8'h20);
    rc(`A_IIR_FCR, 8'h10);
    rc(`A_IIR_FCR, 8'h10);
    pl(4'h2);
    rc(`A_IIR_FCR, 8'h01);
    pl(4'h4);
    rc(`A_IIR_FCR, 8'h10);
    rc(`A_IIR_FCR, 8'h01);
    bus(1'b1, `A_IER, 8'h08);
    setm(4'h0);
    rc(`A_IIR_FCR, 8'h00);
    rc(`A_MSR, 8'hfb);
    rc(`A_IIR_FCR, 8'h01);
    bus(1'b1, `A_IER, 8'h48);
    setm(4'hf);
    rc(`A_IIR_FCR, 8'h00);
    rc(`A_MSR, 8'h0f);
    rc(`A_IIR_FCR, 8'h20);
    rc(`A_IIR_FCR, 8'h01);
    bus(1'b1, `A_IER, 8'h07);
    snd(3'h7);
    rc(`A_IIR_FCR, 8'h06);
    rc(`A_LSR, 8'hfd);
    rc(`A_DATA, 8'h00);
    rc(`A_IIR_FCR, 8'h01);
    rc(`A_LSR, 8'h60);
    snd(3'h0);
    rc(`A_IIR_FCR, 8'h04);
    rc(`A_DATA, 8'h01);
    rc(`A_IIR_FCR, 8'h01);
    snd(3'h0);
    pl(4'h8);
    rc(`A_IIR_FCR, 8'h0c);
    rc(`A_DATA, 8'h02);
    rc(`A_IIR_FCR, 8'h01);
    snd(3'h0);
    snd(3'h0);
    rc(`A_IIR_FCR, 8'h06);
    rc(`A_LSR, 8'h63);
    rc(`A_IIR_FCR, 8'h04);
    rc(`A_DATA, 8'h03);
    $display("interrupt test done");
    bus(1'b1, `A_IER, 8'h00);
    bus(1'b1, `A_IIR_FCR, 8'h01);
    bus(1'b1, `A_TCR, 8'h8f);
    bus(1'b1, `A_EFR, 8'h08);
    fl <= 1'b1;
    go <= 1'b1;
    i = 0;
    while (n_push < 61 && i < 500) begin
      @(posedge clk);
      i = i + 1;
    end
    if (n_push < 61) begin
      fail_count = fail_count + 1;
      $display("BAD %0t flow timeout", $time);
      report_and_stop;
    end
    repeat (10) @(posedge clk);
    go <= 1'b0;
    chk(n_push[7:0], 8'd61);
    for (i = 0; i < 29; i = i + 1) begin
      chk({7'h0, res_seen}, 8'h00);
      rc(`A_DATA, i[7:0] + 8'h05);
    end
    // The resume pulse is logged on the same edge that the bus call returns on
    @(posedge clk);
    chk({7'h0, res_seen}, 8'h01);
    $display("flow test done");
    report_and_stop;
  end
endmodule // uart_irq_top_bench
